// [rtl/cag_addr_gen.sv]
/*
  CPU address generation: register-indirect branch target, implied
  operands, register operands and effective addresses of all operand
  addressing modes, with stack pointer and bank window flagging.
  Assumes a decoder on the same clock that presents one request at a
  time while busy is low, and a memory bus that takes one strobe.
*/
// Contract
// - Indirect branch loads program counter from the full primary word pair.
// - Unsigned multiply takes A and X, writes product into primary pair.
// - Unsigned word divide reads and overwrites primary pair with quotient.
// - Decimal adjust instructions implicitly use the accumulator byte.
// - Digit rotate instructions implicitly use the accumulator byte.
// - Register addressing picks one of eight bytes by 3 bits within bank.
// - Bytes X,A,C,B,E,D,L,H and pairs primary,second,third,base by position.
// - Direct addressing uses the 16-bit immediate unchanged as address.
// - Short direct reaches only FE20H..FF1FH via an 8-bit immediate.
// - Short window: high-speed RAM FE20H..FEFFH, special registers FF00H..FF1FH.
// - Short address upper bits ones; bit 8 set only for immediates below 20H.
// - Special register addressing: page FF00H, excluding FFD0H..FFDFH.
// - Register indirect uses third or base pair of selected bank.
// - Based adds zero-extended 8-bit offset to base pair, carry dropped.
// - Based indexed adds zero-extended B or C to base pair, carry dropped.
// - Push and pop address memory via stack pointer.
// - Stack accesses reach only internal high-speed RAM.
// - Bank window 8000H..BFFFH shows the bank chosen by bank select.
`timescale 1ns/10ps
`default_nettype none
`include "cag_map.svh"
module cag_addr_gen (
  input wire logic clock,
  input wire logic rst,
  input wire logic reqValid,
  input wire cag_pkg::cag_op_type reqOp,
  input wire logic reqWrite,
  input wire logic reqWord,
  input wire logic [2:0] regIdx,
  input wire logic [1:0] pairIdx,
  input wire logic [15:0] immWord,
  input wire logic [7:0] immByte,
  input wire logic reg_bank_sel_lo,
  input wire logic reg_bank_sel_hi,
  input wire logic [2:0] memBankSetting,
  input wire logic spLoad,
  input wire logic [15:0] spValue,
  input wire logic wbEn,
  input wire logic wbWord,
  input wire logic [4:0] wbAddr,
  input wire logic [15:0] wbData,
  output logic busy,
  output logic done,
  output logic fault,
  output logic [15:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic memWord,
  output logic bankWindow,
  output logic [2:0] memBank,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic [15:0] operandData,
  output logic [15:0] stackPtr
);

  cag_pkg::cag_state_type state_r;
  cag_pkg::cag_state_type state_nxt;
  cag_rf_if rf ();

  cag_regfile u_regfile (
    .clock(clock),
    .rf(rf)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Word pair read for each operation
  function automatic logic [1:0] pairFor(input cag_pkg::cag_op_type op,
                                         input logic [1:0] idx);
    case (op)
      cag_pkg::CAG_OP_REG, cag_pkg::CAG_OP_IND: pairFor = idx;
      cag_pkg::CAG_OP_BASED, cag_pkg::CAG_OP_BIDX: pairFor = `CAG_PAIR_BASE;
      default: pairFor = `CAG_PAIR_PRIM;
    endcase
  endfunction

  // Byte register read for each operation
  function automatic logic [2:0] byteFor(input cag_pkg::cag_op_type op,
                                         input logic [2:0] idx);
    case (op)
      cag_pkg::CAG_OP_UNSIGNED_WORD_DIVIDE: byteFor = `CAG_BYTE_C;
      default: byteFor = idx;
    endcase
  endfunction

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic [15:0] pairVal;
  logic [7:0] byteVal;
  logic [15:0] ea;
  logic [15:0] product;
  logic [15:0] quotient;
  logic isMem;
  logic bad;
  logic wr;

  always_comb begin
    state_nxt = state_r;
    pairVal = rf.rdPairData;
    byteVal = rf.rdByteData;
    ea = 16'h0000;
    isMem = 1'b0;
    bad = 1'b0;
    // Stack ops fix their own direction
    wr = state_r.isWrite;
    product = {8'h00, pairVal[15:8]} * {8'h00, pairVal[7:0]};
    if (byteVal == 8'h00) begin
      quotient = `CAG_DIV0_QUOT;
    end else begin
      quotient = pairVal / {8'h00, byteVal};
    end

    // Register store read ports: bank from the latched select flags
    rf.rdPairAddr = {state_r.bank, pairFor(state_r.op, state_r.pairIdx), 1'b0};
    rf.rdByteAddr = {state_r.bank, byteFor(state_r.op, state_r.regIdx)};
    rf.wrEn = wbEn;
    rf.wrWord = wbWord;
    rf.wrAddr = wbAddr;
    rf.wrData = wbData;

    // One-cycle pulses
    state_nxt.done = 1'b0;
    state_nxt.memRead = 1'b0;
    state_nxt.memWrite = 1'b0;
    state_nxt.pcLoad = 1'b0;

    if (spLoad) begin
      state_nxt.sp = spValue;
    end

    case (state_r.state)
      cag_pkg::CAG_ST_IDLE: begin
        if (reqValid && reqOp != cag_pkg::CAG_OP_NONE) begin
          state_nxt.state = cag_pkg::CAG_ST_WAIT;
          state_nxt.busy = 1'b1;
          state_nxt.fault = 1'b0;
          state_nxt.op = reqOp;
          state_nxt.bank = {reg_bank_sel_hi, reg_bank_sel_lo};
          state_nxt.regIdx = regIdx;
          state_nxt.pairIdx = pairIdx;
          state_nxt.imm16 = immWord;
          state_nxt.imm8 = immByte;
          state_nxt.isWrite = reqWrite;
          state_nxt.isWord = reqWord;
        end
      end
      cag_pkg::CAG_ST_WAIT: begin
        // Store samples its read address here
        state_nxt.state = cag_pkg::CAG_ST_EXEC;
      end
      cag_pkg::CAG_ST_EXEC: begin
        state_nxt.state = cag_pkg::CAG_ST_IDLE;
        state_nxt.busy = 1'b0;
        state_nxt.done = 1'b1;
        case (state_r.op)
          cag_pkg::CAG_OP_BR_PAIR: begin
            state_nxt.pcLoad = 1'b1;
            state_nxt.pcValue = pairVal;
          end
          cag_pkg::CAG_OP_UNSIGNED_MULTIPLY: begin
            rf.wrEn = 1'b1;
            rf.wrWord = 1'b1;
            rf.wrAddr = {state_r.bank, `CAG_PAIR_PRIM, 1'b0};
            rf.wrData = product;
            state_nxt.operand = product;
          end
          cag_pkg::CAG_OP_UNSIGNED_WORD_DIVIDE: begin
            rf.wrEn = 1'b1;
            rf.wrWord = 1'b1;
            rf.wrAddr = {state_r.bank, `CAG_PAIR_PRIM, 1'b0};
            rf.wrData = quotient;
            state_nxt.operand = quotient;
          end
          cag_pkg::CAG_OP_ADJ: begin
            state_nxt.operand = {8'h00, pairVal[15:8]};
          end
          cag_pkg::CAG_OP_ROT: begin
            state_nxt.operand = {8'h00, pairVal[15:8]};
          end
          cag_pkg::CAG_OP_REG: begin
            if (state_r.isWord) begin
              state_nxt.operand = pairVal;
            end else begin
              state_nxt.operand = {8'h00, byteVal};
            end
          end
          cag_pkg::CAG_OP_DIRECT: begin
            ea = state_r.imm16;
            isMem = 1'b1;
          end
          cag_pkg::CAG_OP_SHORT: begin
            // Bit 8 low for RAM part, high for register part
            ea = {`CAG_SADDR_PAGE, (state_r.imm8 < `CAG_SADDR_SFR_LIMIT), state_r.imm8};
            isMem = 1'b1;
          end
          cag_pkg::CAG_OP_SFR: begin
            ea = {`CAG_SFR_PAGE, state_r.imm8};
            bad = (state_r.imm8 >= `CAG_SFR_GAP_LO) && (state_r.imm8 <= `CAG_SFR_GAP_HI);
            isMem = 1'b1;
          end
          cag_pkg::CAG_OP_IND: begin
            ea = pairVal;
            bad = (state_r.pairIdx != `CAG_PAIR_THIRD) && (state_r.pairIdx != `CAG_PAIR_BASE);
            isMem = 1'b1;
          end
          cag_pkg::CAG_OP_BASED: begin
            ea = pairVal + {8'h00, state_r.imm8};
            isMem = 1'b1;
          end
          cag_pkg::CAG_OP_BIDX: begin
            ea = pairVal + {8'h00, byteVal};
            bad = (state_r.regIdx != `CAG_BYTE_B) && (state_r.regIdx != `CAG_BYTE_C);
            isMem = 1'b1;
          end
          cag_pkg::CAG_OP_PUSH: begin
            ea = state_r.sp - 16'h0001;
            bad = !inRange(ea, `CAG_HSRAM_LO, `CAG_HSRAM_HI);
            isMem = 1'b1;
            wr = 1'b1;
            if (!bad && !spLoad) begin
              state_nxt.sp = ea;
            end
          end
          cag_pkg::CAG_OP_POP: begin
            ea = state_r.sp;
            bad = !inRange(ea, `CAG_HSRAM_LO, `CAG_HSRAM_HI);
            isMem = 1'b1;
            wr = 1'b0;
            if (!bad && !spLoad) begin
              state_nxt.sp = state_r.sp + 16'h0001;
            end
          end
          default: begin
            bad = 1'b1;
          end
        endcase
        state_nxt.fault = bad;
        if (isMem && !bad) begin
          // Address and one strobe go out together
          state_nxt.memAddr = ea;
          state_nxt.memRead = !wr;
          state_nxt.memWrite = wr;
          state_nxt.memWord = state_r.isWord;
          state_nxt.bankWin = inRange(ea, `CAG_BANK_LO, `CAG_BANK_HI);
          state_nxt.memBank = memBankSetting;
        end
      end
      default: begin
        state_nxt.state = cag_pkg::CAG_ST_IDLE;
        state_nxt.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= '0;
      state_r.state <= cag_pkg::CAG_ST_IDLE;
      state_r.op <= cag_pkg::CAG_OP_NONE;
      state_r.sp <= `CAG_SP_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign busy = state_r.busy;
  assign done = state_r.done;
  assign fault = state_r.fault;
  assign memAddr = state_r.memAddr;
  assign memRead = state_r.memRead;
  assign memWrite = state_r.memWrite;
  assign memWord = state_r.memWord;
  assign bankWindow = state_r.bankWin;
  assign memBank = state_r.memBank;
  assign pcLoad = state_r.pcLoad;
  assign pcValue = state_r.pcValue;
  assign operandData = state_r.operand;
  assign stackPtr = state_r.sp;

endmodule
`default_nettype wire

// [rtl/cag_map.svh]
/*
  Constants of the CPU address generation block: windows, limits,
  register positions and reset values.
  Assumes inclusion by bare name from the address generator design file.
*/
`ifndef CAG_MAP_SVH
`define CAG_MAP_SVH

// Short direct window
`define CAG_SADDR_PAGE 7'h7F
`define CAG_SADDR_SFR_LIMIT 8'h20
// Special function register page and its hole
`define CAG_SFR_PAGE 8'hFF
`define CAG_SFR_GAP_LO 8'hD0
`define CAG_SFR_GAP_HI 8'hDF
// Internal high-speed RAM, the only stack target
`define CAG_HSRAM_LO 16'hFB00
`define CAG_HSRAM_HI 16'hFEFF
// Banked program memory window
`define CAG_BANK_LO 16'h8000
`define CAG_BANK_HI 16'hBFFF
// Byte register positions
`define CAG_BYTE_X 3'h0
`define CAG_BYTE_A 3'h1
`define CAG_BYTE_C 3'h2
`define CAG_BYTE_B 3'h3
// Word pair positions
`define CAG_PAIR_PRIM 2'h0
`define CAG_PAIR_THIRD 2'h2
`define CAG_PAIR_BASE 2'h3
// Reset and fallback values
`define CAG_SP_RESET 16'hFF00
`define CAG_DIV0_QUOT 16'hFFFF

`endif

// [rtl/cag_pkg.sv]
/*
  Types of the CPU address generation block.
  Assumes cag_map.svh on the include path.
*/
`default_nettype none
package cag_pkg;

  typedef enum logic [3:0] {
    CAG_OP_NONE, CAG_OP_BR_PAIR, CAG_OP_UNSIGNED_MULTIPLY, CAG_OP_UNSIGNED_WORD_DIVIDE, CAG_OP_ADJ, CAG_OP_ROT,
    CAG_OP_REG, CAG_OP_DIRECT, CAG_OP_SHORT, CAG_OP_SFR, CAG_OP_IND, CAG_OP_BASED,
    CAG_OP_BIDX, CAG_OP_PUSH, CAG_OP_POP
  } cag_op_type;

  typedef enum logic [1:0] {CAG_ST_IDLE, CAG_ST_WAIT, CAG_ST_EXEC} cag_st_type;

  typedef struct packed {
    cag_st_type state;
    cag_op_type op;
    logic [1:0] bank;
    logic [2:0] regIdx;
    logic [1:0] pairIdx;
    logic [15:0] imm16;
    logic [7:0] imm8;
    logic isWrite;
    logic isWord;
    logic [15:0] sp;
    logic busy;
    logic done;
    logic fault;
    logic [15:0] memAddr;
    logic memRead;
    logic memWrite;
    logic memWord;
    logic bankWin;
    logic [2:0] memBank;
    logic pcLoad;
    logic [15:0] pcValue;
    logic [15:0] operand;
  } cag_state_type;

endpackage
`default_nettype wire

// [rtl/cag_regfile.sv]
/*
  Register bank store: four banks of eight byte registers, one word
  read port, one byte read port, one byte or word write port.
  Assumes addresses are {bank, byte position}; word addresses even.
*/
`timescale 1ns/10ps
`default_nettype none
module cag_regfile (
  input wire logic clock,
  cag_rf_if.store rf
);

  logic [7:0] mem [0:31];
  logic [15:0] pairData_r;
  logic [7:0] byteData_r;

  // Read data come out of registers, one cycle after the address
  always_ff @(posedge clock) begin
    pairData_r <= {mem[{rf.rdPairAddr[4:1], 1'b1}], mem[{rf.rdPairAddr[4:1], 1'b0}]};
    byteData_r <= mem[rf.rdByteAddr];
    if (rf.wrEn) begin
      if (rf.wrWord) begin
        mem[{rf.wrAddr[4:1], 1'b0}] <= rf.wrData[7:0];
        mem[{rf.wrAddr[4:1], 1'b1}] <= rf.wrData[15:8];
      end else begin
        mem[rf.wrAddr] <= rf.wrData[7:0];
      end
    end
  end

  assign rf.rdPairData = pairData_r;
  assign rf.rdByteData = byteData_r;

endmodule
`default_nettype wire

// [rtl/cag_rf_if.sv]
/*
  Carrier between the address generator and its register bank store.
  Assumes both ends on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface cag_rf_if;
  logic [4:0] rdPairAddr;
  logic [4:0] rdByteAddr;
  logic [15:0] rdPairData;
  logic [7:0] rdByteData;
  logic wrEn;
  logic wrWord;
  logic [4:0] wrAddr;
  logic [15:0] wrData;

  modport ctrl (
    output rdPairAddr, rdByteAddr, wrEn, wrWord, wrAddr, wrData,
    input rdPairData, rdByteData
  );
  modport store (
    input rdPairAddr, rdByteAddr, wrEn, wrWord, wrAddr, wrData,
    output rdPairData, rdByteData
  );
endinterface
`default_nettype wire

// [tb/cag_addr_gen_asserts.sv]
/*
  Checker for the address generator top ports.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cag_addr_gen_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic reqValid,
  input wire cag_pkg::cag_op_type reqOp,
  input wire logic [15:0] immWord,
  input wire logic [7:0] immByte,
  input wire logic [2:0] memBankSetting,
  input wire logic busy,
  input wire logic done,
  input wire logic fault,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic bankWindow,
  input wire logic [2:0] memBank,
  input wire logic pcLoad,
  input wire logic [15:0] stackPtr
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic acc;
  logic stb;
  cag_pkg::cag_op_type opR;
  logic [15:0] wordR;
  logic [7:0] byteR;
  assign acc = reqValid && reqOp != cag_pkg::CAG_OP_NONE && !busy;
  assign stb = memRead || memWrite;
  // Request fields kept until the answer
  always_ff @(posedge clock) begin
    if (acc) begin
      opR <= reqOp;
      wordR <= immWord;
      byteR <= immByte;
    end
  end
  ////////////////////////////////////////////////////////////
  a_done_latency:
    assert property (acc |-> ##3 done) else $error("done late");
  a_busy_span:
    assert property (acc |=> busy ##1 busy ##1 !busy) else $error("busy span wrong");
  a_strobe_single:
    assert property (stb |-> done && !fault ##1 !stb) else $error("strobe wrong");
  a_short_addr:
    assert property (done && opR == cag_pkg::CAG_OP_SHORT |->
      stb && memAddr == {7'h7F, byteR < 8'h20, byteR}) else $error("short addr");
  a_sfr_addr:
    assert property (done && opR == cag_pkg::CAG_OP_SFR |-> ((byteR inside {[8'hD0:8'hDF]})
      ? fault && !stb : stb && memAddr == {8'hFF, byteR})) else $error("sfr addr");
  a_direct_addr:
    assert property (done && opR == cag_pkg::CAG_OP_DIRECT |-> stb && memAddr == wordR)
      else $error("direct addr");
  a_bank_flag:
    assert property (stb |-> bankWindow == (memAddr inside {[16'h8000:16'hBFFF]})
      && memBank == $past(memBankSetting)) else $error("bank window");
  a_push_sp:
    assert property (done && opR == cag_pkg::CAG_OP_PUSH && !fault |-> memWrite
      && memAddr == stackPtr && stackPtr == $past(stackPtr) - 16'h0001) else $error("push");
  a_stack_ram:
    assert property (done && opR inside {cag_pkg::CAG_OP_PUSH, cag_pkg::CAG_OP_POP} && stb
      |-> memAddr inside {[16'hFB00:16'hFEFF]}) else $error("stack outside ram");
  a_pc_branch:
    assert property (pcLoad |-> done && opR == cag_pkg::CAG_OP_BR_PAIR) else $error("pc");
  c_fault: cover property (done && fault);
  c_window: cover property (stb && bankWindow);
  c_branch: cover property (pcLoad);
endmodule
bind cag_addr_gen cag_addr_gen_asserts u_asserts (.clock, .rst, .reqValid, .reqOp, .immWord,
  .immByte, .memBankSetting, .busy, .done, .fault, .memAddr, .memRead, .memWrite,
  .bankWindow, .memBank, .pcLoad, .stackPtr);
`default_nettype wire

// [tb/cag_bus_model.sv]
/*
  Memory bus sink: counts operand strobes.
  Assumes strobes are one-cycle pulses on the CPU clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cag_bus_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic memRead,
  input wire logic memWrite,
  output logic [15:0] strobeCount
);
  always_ff @(posedge clock) begin
    if (rst) begin
      strobeCount <= 16'h0000;
    end else begin
      strobeCount <= strobeCount + 16'(memRead) + 16'(memWrite);
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
  Bench for the address generator: random and corner requests.
  Assumes the bound checker and the bus model beside the design.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic reqValid = 1'h0;
  cag_pkg::cag_op_type reqOp = cag_pkg::CAG_OP_NONE;
  logic reqWrite = 1'h0;
  logic reqWord = 1'h0;
  logic [2:0] regIdx = 3'h0;
  logic [1:0] pairIdx = 2'h0;
  logic [15:0] immWord = 16'h0000;
  logic [7:0] immByte = 8'h00;
  logic [1:0] bk = 2'h0;
  logic [2:0] memBankSetting = 3'h0;
  logic spLoad = 1'h0;
  logic [15:0] spValue = 16'h0000;
  logic wbEn = 1'h0;
  logic wbWord = 1'h0;
  logic [4:0] wbAddr = 5'h00;
  logic [15:0] wbData = 16'h0000;
  logic busy, done, fault, memRead, memWrite, memWord, bankWindow, pcLoad;
  logic [15:0] memAddr, pcValue, operandData, stackPtr, strobeCount, e;
  logic [2:0] memBank, r;
  logic [7:0] a;
  logic f;
  logic [7:0] sh [32];
  logic [7:0] sc [4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
  logic [7:0] sf [4] = '{8'hCF, 8'hD0, 8'hDF, 8'hE0};
  logic [15:0] dc [4] = '{16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000};
  int seed = 14;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int expStb = 0;
  always #4 clock = ~clock;
  cag_addr_gen dut (.clock, .rst, .reqValid, .reqOp, .reqWrite, .reqWord, .regIdx, .pairIdx,
    .immWord, .immByte, .reg_bank_sel_lo(bk[0]), .reg_bank_sel_hi(bk[1]), .memBankSetting,
    .spLoad, .spValue, .wbEn, .wbWord, .wbAddr, .wbData, .busy, .done, .fault, .memAddr,
    .memRead, .memWrite, .memWord, .bankWindow, .memBank, .pcLoad, .pcValue, .operandData,
    .stackPtr);
  cag_bus_model bus (.clock, .rst, .memRead, .memWrite, .strobeCount);
  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] s);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  function automatic logic [15:0] pr(input logic [1:0] p);
    return {sh[{bk, p, 1'h1}], sh[{bk, p, 1'h0}]};
  endfunction
  task automatic wbw(input logic [1:0] p, input logic [15:0] d);
    wbEn = 1'h1;
    wbWord = 1'h1;
    wbAddr = {bk, p, 1'h0};
    wbData = d;
    {sh[{bk, p, 1'h1}], sh[{bk, p, 1'h0}]} = d;
    @(posedge clock);
    #1 wbEn = 1'h0;
    // Idle cycle between back-to-back writes
    @(posedge clock);
    #1;
  endtask
  task automatic go(input cag_pkg::cag_op_type op, input logic w, input logic [7:0] ib,
      input logic [2:0] ri, input logic ef);
    int n;
    logic m;
    reqOp = op;
    reqWrite = w;
    immByte = ib;
    regIdx = ri;
    pairIdx = ri[1:0];
    reqValid = 1'h1;
    @(posedge clock);
    #1 reqValid = 1'h0;
    n = 0;
    m = op >= cag_pkg::CAG_OP_DIRECT && !ef;
    while (done !== 1'h1 && n < 10) begin
      @(posedge clock);
      #1 n++;
    end
    chk("fault", {15'h0000, ef}, {15'h0000, fault});
    chk("strobes", {14'h0000, m & w, m & !w}, {14'h0000, memWrite, memRead});
    chk("pc load", {15'h0000, op == cag_pkg::CAG_OP_BR_PAIR}, {15'h0000, pcLoad});
    expStb += m;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 1'h0;
    chk("sp reset", 16'hFF00, stackPtr);
    chk("idle", 16'h0000, {busy, done, fault, memRead, memWrite, pcLoad, memAddr[9:0]});
    $display("test reset done");
    for (int b = 0; b < 4; b++) begin
      bk = 2'(b);
      for (int p = 0; p < 4; p++) wbw(2'(p), 16'($random(seed)));
    end
    for (int i = 0; i < 24; i++) begin
      bk = 2'($random(seed));
      e = 16'($random(seed));
      a = (i < 4) ? sc[i] : e[7:0];
      immWord = (i < 4) ? dc[i] : e;
      memBankSetting = 3'($random(seed));
      go(cag_pkg::CAG_OP_SHORT, 1'h0, a, 3'h0, 1'h0);
      chk("short", {7'h7F, a < 8'h20, a}, memAddr);
      a = (i < 4) ? sf[i] : e[15:8];
      f = a inside {[8'hD0:8'hDF]};
      go(cag_pkg::CAG_OP_SFR, 1'h1, a, 3'h0, f);
      if (!f) chk("sfr", {8'hFF, a}, memAddr);
      reqWord = e[1];
      go(cag_pkg::CAG_OP_DIRECT, e[0], 8'h00, 3'h0, 1'h0);
      chk("direct", immWord, memAddr);
      chk("word", {15'h0000, e[1]}, {15'h0000, memWord});
      reqWord = 1'h0;
      f = immWord inside {[16'h8000:16'hBFFF]};
      chk("window", {12'h000, f, memBankSetting}, {12'h000, bankWindow, memBank});
      r = {2'h1, i[0]};
      go(cag_pkg::CAG_OP_IND, 1'h0, 8'h00, r, 1'h0);
      chk("indirect", pr(r[1:0]), memAddr);
      go(cag_pkg::CAG_OP_BIDX, 1'h1, 8'h00, r, 1'h0);
      chk("indexed", pr(2'h3) + {8'h00, sh[{bk, r}]}, memAddr);
      if (i == 1) wbw(2'h3, 16'hFFF0);
      a = (i < 4) ? 8'hFF : e[15:8];
      go(cag_pkg::CAG_OP_BASED, 1'h0, a, 3'h0, 1'h0);
      chk("based", pr(2'h3) + {8'h00, a}, memAddr);
      r = 3'(i);
      go(cag_pkg::CAG_OP_REG, 1'h0, 8'h00, r, 1'h0);
      chk("reg byte", {8'h00, sh[{bk, r}]}, operandData);
      reqWord = 1'h1;
      go(cag_pkg::CAG_OP_REG, 1'h0, 8'h00, r, 1'h0);
      chk("reg pair", pr(r[1:0]), operandData);
      reqWord = 1'h0;
      go(cag_pkg::CAG_OP_ADJ, 1'h0, 8'h00, 3'h0, 1'h0);
      chk("adjust", {8'h00, sh[{bk, 3'h1}]}, operandData);
      go(cag_pkg::CAG_OP_ROT, 1'h0, 8'h00, 3'h0, 1'h0);
      chk("rotate", {8'h00, sh[{bk, 3'h1}]}, operandData);
      e = {8'h00, sh[{bk, 3'h1}]} * {8'h00, sh[{bk, 3'h0}]};
      go(cag_pkg::CAG_OP_UNSIGNED_MULTIPLY, 1'h0, 8'h00, 3'h0, 1'h0);
      chk("product", e, operandData);
      {sh[{bk, 3'h1}], sh[{bk, 3'h0}]} = e;
      go(cag_pkg::CAG_OP_BR_PAIR, 1'h0, 8'h00, 3'h0, 1'h0);
      chk("target", pr(2'h0), pcValue);
      if (i == 0) wbw(2'h1, 16'h5A00);
      e = (sh[{bk, 3'h2}] == 8'h00) ? 16'hFFFF : pr(2'h0) / {8'h00, sh[{bk, 3'h2}]};
      go(cag_pkg::CAG_OP_UNSIGNED_WORD_DIVIDE, 1'h0, 8'h00, 3'h0, 1'h0);
      chk("quotient", e, operandData);
      {sh[{bk, 3'h1}], sh[{bk, 3'h0}]} = e;
    end
    $display("test random done");
    go(cag_pkg::CAG_OP_IND, 1'h0, 8'h00, 3'h1, 1'h1);
    go(cag_pkg::CAG_OP_BIDX, 1'h0, 8'h00, 3'h4, 1'h1);
    go(cag_pkg::CAG_OP_PUSH, 1'h1, 8'h00, 3'h0, 1'h0);
    chk("push", 16'hFEFF, memAddr);
    go(cag_pkg::CAG_OP_POP, 1'h0, 8'h00, 3'h0, 1'h0);
    chk("pop", 16'hFEFF, memAddr);
    go(cag_pkg::CAG_OP_POP, 1'h0, 8'h00, 3'h0, 1'h1);
    chk("pop sp", 16'hFF00, stackPtr);
    spLoad = 1'h1;
    spValue = 16'hFB00;
    @(posedge clock);
    #1 spLoad = 1'h0;
    go(cag_pkg::CAG_OP_PUSH, 1'h1, 8'h00, 3'h0, 1'h1);
    go(cag_pkg::CAG_OP_POP, 1'h0, 8'h00, 3'h0, 1'h0);
    chk("low pop", 16'hFB00, memAddr);
    chk("low sp", 16'hFB01, stackPtr);
    reqValid = 1'h1;
    reqOp = cag_pkg::CAG_OP_NONE;
    repeat (4) @(posedge clock);
    #1 reqValid = 1'h0;
    chk("none", 16'h0000, {14'h0000, busy, done});
    chk("strobe count", 16'(expStb), strobeCount);
    $display("test stack done");
    final_report();
  end
endmodule
`default_nettype wire
